// [dprs_en_if.sv]
// interface carrying synchronised enable levels between sequencer modules
`timescale 1ns/1ps
interface dprs_en_if;
  logic wlan_en;
  logic radio_en;
  modport src (output wlan_en, output radio_en);
  modport dst (input wlan_en, input radio_en);
endinterface

// [dprs_host_model.sv]
// host model driving the two power enable lines of the sequencer
`timescale 1ns/1ps
module dprs_host_model
  import dprs_pkg::*;
#(
  parameter int unsigned OFF_CYCLES = 10 // regulator discharge time in cycles
) (
  input  wire logic sys_clk_i, // system clock
  output logic      wlan_o,    // wlan power enable
  output logic      radio_o    // radio power enable
);
  initial begin
    wlan_o  = 1'b0;
    radio_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // changes levels just after a falling edge; delays are minimums only
  task automatic drive(input logic w, input logic r);
    if (!wlan_o && !radio_o && (w || r)) begin
      repeat (OFF_CYCLES + 2) @(negedge sys_clk_i);
    end
    @(negedge sys_clk_i);
    wlan_o  = w;
    radio_o = r;
  endtask
endmodule

// [dprs_pkg.sv]
// package of constants and types for the dual enable power and reset sequencer
package dprs_pkg;
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned POR_HOLD_MAX_MS  = 110;
  localparam int unsigned HOST_WAIT_MIN_MS = 150;
  localparam int unsigned OFF_TIME_MIN_MS  = 10;
  // longest time rounds down
  localparam int unsigned POR_HOLD_CYC     = (POR_HOLD_MAX_MS * (CLK_HZ / 1000));
  localparam int unsigned HOST_WAIT_CYC    = (HOST_WAIT_MIN_MS * (CLK_HZ / 1000));
  localparam int unsigned OFF_TIME_CYC     = (OFF_TIME_MIN_MS * (CLK_HZ / 1000));
  localparam int unsigned CNT_W            = 32;
  localparam logic        SYNC_RST_VAL     = 1'b0;

  typedef enum logic [1:0] {
    DPRS_OFF,
    DPRS_POR_HOLD,
    DPRS_RUN
  } dprs_state_e;
endpackage

// [dprs_sync.sv]
// two flip-flop synchroniser for both power enable inputs
`timescale 1ns/1ps
module dprs_sync
  import dprs_pkg::*;
(
  input  wire logic   sys_clk_i,              // system clock
  input  wire logic   rst_i,                  // sync reset, active high
  input  wire logic   wlan_power_enable_in_i, // wlan enable pin
  input  wire logic   radio_power_enable_in_i,// radio enable pin
  dprs_en_if.src      en                      // synchronised levels
);
  logic [1:0] s1_q;
  logic [1:0] s1_d;
  logic [1:0] s2_q;
  logic [1:0] s2_d;

  always_comb begin
    s1_d = {radio_power_enable_in_i, wlan_power_enable_in_i};
    s2_d = s1_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s1_q <= {2{SYNC_RST_VAL}};
      s2_q <= {2{SYNC_RST_VAL}};
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign en.wlan_en  = s2_q[0];
  assign en.radio_en = s2_q[1];
endmodule

// [dprs_top.sv]
// dual enable power and reset sequencer top
`timescale 1ns/1ps
module dprs_top
  import dprs_pkg::*;
#(
  parameter int unsigned POR_CYCLES  = POR_HOLD_CYC,  // power-on hold length
  parameter int unsigned WAIT_CYCLES = HOST_WAIT_CYC, // host access ready delay
  parameter int unsigned OFF_CYCLES  = OFF_TIME_CYC   // regulator discharge time
) (
  input  wire logic sys_clk_i,               // system clock, 20 MHz
  input  wire logic rst_i,                   // sync reset, active high
  input  wire logic wlan_power_enable_in_i,  // wlan enable from host
  input  wire logic radio_power_enable_in_i, // radio enable from host
  input  wire logic supplies_good_i,         // core and io supply over threshold
  output logic      regulator_en_o,          // internal regulators on
  output logic      wlan_rst_o,              // wlan section in reset, high active
  output logic      radio_rst_o,             // radio section in reset, high active
  output logic      por_active_o,            // power-on reset hold running
  output logic      host_bus_ready_o,        // host bus access allowed
  output logic      discharge_busy_o         // off time not yet elapsed
);

  // refuse cycle counts the sequencer cannot serve
  if (POR_CYCLES < 1 || WAIT_CYCLES <= POR_CYCLES || OFF_CYCLES < 1) begin : g_bad_cycles
    $error("dprs_top: bad cycle parameters");
  end

  dprs_en_if en_if ();

  dprs_sync u_sync (
    .sys_clk_i               (sys_clk_i),
    .rst_i                   (rst_i),
    .wlan_power_enable_in_i  (wlan_power_enable_in_i),
    .radio_power_enable_in_i (radio_power_enable_in_i),
    .en                      (en_if.src)
  );

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v,
                                               input int unsigned lim);
    sat_inc = (v >= CNT_W'(lim)) ? v : v + CNT_W'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  dprs_state_e      st_q;
  dprs_state_e      st_d;
  logic [CNT_W-1:0] por_cnt_q;
  logic [CNT_W-1:0] por_cnt_d;
  logic [CNT_W-1:0] wait_cnt_q;
  logic [CNT_W-1:0] wait_cnt_d;
  logic [CNT_W-1:0] off_cnt_q;
  logic [CNT_W-1:0] off_cnt_d;
  logic             any_en;

  assign any_en = en_if.wlan_en | en_if.radio_en;

  always_comb begin
    st_d       = st_q;
    por_cnt_d  = por_cnt_q;
    wait_cnt_d = wait_cnt_q;
    off_cnt_d  = sat_inc(off_cnt_q, OFF_CYCLES);
    case (st_q)
      DPRS_OFF: begin
        por_cnt_d  = '0;
        wait_cnt_d = '0;
        if (any_en && supplies_good_i) begin
          st_d = DPRS_POR_HOLD;
        end
      end
      DPRS_POR_HOLD: begin
        por_cnt_d  = sat_inc(por_cnt_q, POR_CYCLES);
        wait_cnt_d = sat_inc(wait_cnt_q, WAIT_CYCLES);
        if (!any_en || !supplies_good_i) begin
          st_d = DPRS_OFF;
        end else if (por_cnt_q >= CNT_W'(POR_CYCLES - 1)) begin
          st_d = DPRS_RUN;
        end
      end
      DPRS_RUN: begin
        wait_cnt_d = sat_inc(wait_cnt_q, WAIT_CYCLES);
        if (!any_en || !supplies_good_i) begin
          st_d = DPRS_OFF;
        end
      end
      default: begin
        st_d = DPRS_OFF;
      end
    endcase
    if (any_en) begin
      off_cnt_d = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_q       <= DPRS_OFF;
      por_cnt_q  <= '0;
      wait_cnt_q <= '0;
      off_cnt_q  <= '0;
    end else begin
      st_q       <= st_d;
      por_cnt_q  <= por_cnt_d;
      wait_cnt_q <= wait_cnt_d;
      off_cnt_q  <= off_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic reg_en_d;
  logic wlan_rst_d;
  logic radio_rst_d;
  logic por_d;
  logic ready_d;
  logic busy_d;

  always_comb begin
    reg_en_d    = any_en;
    por_d       = (st_d == DPRS_POR_HOLD);
    wlan_rst_d  = !(st_d == DPRS_RUN && en_if.wlan_en);
    radio_rst_d = !(st_d == DPRS_RUN && en_if.radio_en);
    ready_d     = (st_d != DPRS_OFF) && (wait_cnt_d >= CNT_W'(WAIT_CYCLES));
    busy_d      = !any_en && (off_cnt_d < CNT_W'(OFF_CYCLES));
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      regulator_en_o   <= 1'b0;
      wlan_rst_o       <= 1'b1;
      radio_rst_o      <= 1'b1;
      por_active_o     <= 1'b0;
      host_bus_ready_o <= 1'b0;
      discharge_busy_o <= 1'b0;
    end else begin
      regulator_en_o   <= reg_en_d;
      wlan_rst_o       <= wlan_rst_d;
      radio_rst_o      <= radio_rst_d;
      por_active_o     <= por_d;
      host_bus_ready_o <= ready_d;
      discharge_busy_o <= busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // helper counts taken from the outputs alone, apart from the sequencer counters
  logic             up_now;
  logic [CNT_W-1:0] hold_len_q;
  logic [CNT_W-1:0] hold_len_d;
  logic [CNT_W-1:0] up_len_q;
  logic [CNT_W-1:0] up_len_d;

  assign up_now = por_active_o | ~wlan_rst_o | ~radio_rst_o;

  always_comb begin
    hold_len_d = '0;
    up_len_d   = '0;
    if (por_active_o) begin
      hold_len_d = sat_inc(hold_len_q, POR_CYCLES);
    end
    if (up_now) begin
      up_len_d = sat_inc(up_len_q, WAIT_CYCLES);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hold_len_q <= '0;
      up_len_q   <= '0;
    end else begin
      hold_len_q <= hold_len_d;
      up_len_q   <= up_len_d;
    end
  end

  sequence s_both_low;
    !en_if.wlan_en && !en_if.radio_en;
  endsequence

  // hold has just ended
  sequence s_hold_end;
    $fell(por_active_o);
  endsequence

  chk_reg_or_on: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (en_if.wlan_en || en_if.radio_en) |=> regulator_en_o)
    else $error("regulators off while an enable is high");

  chk_reg_both_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_both_low |=> !regulator_en_o && wlan_rst_o && radio_rst_o)
    else $error("regulators on with both enables low");

  chk_wlan_rst_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !en_if.wlan_en |=> wlan_rst_o)
    else $error("wlan out of reset with enable low");

  chk_radio_rst_held: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!en_if.radio_en && en_if.wlan_en) |=> radio_rst_o && regulator_en_o)
    else $error("radio not held in reset");

  chk_por_bound: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    por_active_o |-> por_cnt_q <= CNT_W'(POR_CYCLES))
    else $error("power-on hold too long");

  chk_ready_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(host_bus_ready_o) |-> $past(wait_cnt_q) >= CNT_W'(WAIT_CYCLES - 1))
    else $error("host ready before wait elapsed");

  chk_hold_rst: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    por_active_o |-> wlan_rst_o && radio_rst_o)
    else $error("section released during power-on hold");

  chk_discharge: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ($fell(regulator_en_o) ##0 s_both_low) |-> discharge_busy_o)
    else $error("discharge window not flagged");

  chk_hold_len: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    por_active_o |-> hold_len_q < CNT_W'(POR_CYCLES))
    else $error("power-on hold longer than its bound");

  chk_ready_len: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    host_bus_ready_o |-> up_len_q >= CNT_W'(WAIT_CYCLES))
    else $error("host ready before the wait span");

  chk_wlan_release: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s_hold_end ##0 $past(!rst_i && en_if.wlan_en && supplies_good_i)) |-> !wlan_rst_o)
    else $error("wlan held in reset after the hold");

  chk_radio_release: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s_hold_end ##0 $past(!rst_i && en_if.radio_en && supplies_good_i)) |-> !radio_rst_o)
    else $error("radio held in reset after the hold");
endmodule

// [dprs_top_tb.sv]
// self-checking testbench for the power and reset sequencer
`timescale 1ns/1ps
module dprs_top_tb;
  import dprs_pkg::*;
  localparam int unsigned P = 20;
  localparam int unsigned W = 30;
  localparam int unsigned O = 10;
  logic sys_clk_i = 1'b0;
  logic rst_i     = 1'b1;
  logic sup_good  = 1'b1;
  logic wl_en;
  logic rd_en;
  logic reg_en;
  logic wl_rst;
  logic rd_rst;
  logic por_act;
  logic bus_rdy;
  logic dis_busy;
  int   err_count    = 0;
  int   total_checks = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  dprs_host_model #(.OFF_CYCLES(O)) host (.sys_clk_i(sys_clk_i), .wlan_o(wl_en), .radio_o(rd_en));
  dprs_top #(.POR_CYCLES(P), .WAIT_CYCLES(W), .OFF_CYCLES(O)) DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wlan_power_enable_in_i(wl_en),
    .radio_power_enable_in_i(rd_en), .supplies_good_i(sup_good), .regulator_en_o(reg_en),
    .wlan_rst_o(wl_rst), .radio_rst_o(rd_rst), .por_active_o(por_act),
    .host_bus_ready_o(bus_rdy), .discharge_busy_o(dis_busy));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic s, input logic e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: got %b want %b", $time, s, e);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(reg_en, 1'b0);
    chk(wl_rst, 1'b1);
    chk(rd_rst, 1'b1);
    chk(por_act, 1'b0);
    chk(bus_rdy, 1'b0);
  endtask
  task automatic t_wlan_only();
    host.drive(1'b1, 1'b0);
    w(2);
    chk(reg_en, 1'b0);
    w(2);
    chk(reg_en, 1'b1);
    chk(por_act, 1'b1);
    chk(wl_rst, 1'b1);
    w(P - 4);
    chk(wl_rst, 1'b1);
    chk(rd_rst, 1'b1);
    chk(por_act, 1'b1);
    w(6);
    chk(por_act, 1'b0);
    chk(wl_rst, 1'b0);
    chk(bus_rdy, 1'b0);
    chk(rd_rst, 1'b1);
    chk(reg_en, 1'b1);
    w(W - P + 4);
    chk(bus_rdy, 1'b1);
    host.drive(1'b0, 1'b0);
    w(4);
    chk(reg_en, 1'b0);
    chk(wl_rst, 1'b1);
    chk(dis_busy, 1'b1);
    chk(bus_rdy, 1'b0);
    w(O + 4);
    chk(dis_busy, 1'b0);
  endtask
  task automatic t_radio_first();
    host.drive(1'b0, 1'b1);
    w(P + 6);
    chk(reg_en, 1'b1);
    chk(rd_rst, 1'b0);
    chk(wl_rst, 1'b1);
    host.drive(1'b1, 1'b1);
    w(4);
    chk(wl_rst, 1'b0);
    chk(rd_rst, 1'b0);
    host.drive(1'b1, 1'b0);
    w(4);
    chk(rd_rst, 1'b1);
    chk(reg_en, 1'b1);
    chk(wl_rst, 1'b0);
    host.drive(1'b0, 1'b0);
    w(4);
    chk(reg_en, 1'b0);
    chk(rd_rst, 1'b1);
  endtask
  task automatic t_no_supply();
    sup_good = 1'b0;
    host.drive(1'b1, 1'b0);
    w(P + 6);
    chk(por_act, 1'b0);
    chk(wl_rst, 1'b1);
    chk(reg_en, 1'b1);
    sup_good = 1'b1;
    w(2);
    chk(por_act, 1'b1);
    w(P);
    chk(por_act, 1'b0);
    chk(wl_rst, 1'b0);
    sup_good = 1'b0;
    w(1);
    chk(wl_rst, 1'b1);
    chk(reg_en, 1'b1);
    host.drive(1'b0, 1'b0);
    w(4);
    sup_good = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    w(6);
    rst_i = 1'b0;
    w(1);
    t_reset();
    t_wlan_only();
    t_radio_first();
    t_no_supply();
    end_sim();
  end
  initial begin
    #(3000 * 50);
    err_count++;
    end_sim();
  end
endmodule
